// >>> design/temp_limit_result_regs.sv
// limit fractions, local result fraction with pair lock, overtemp limits and hysteresis
// assumes req strobes last one cycle and come from the serial pointer front end
module temp_limit_result_regs
   import temp_limit_pkg::*;
(
   input  wire logic             sys_clk,
   input  wire logic             srst,
   input  wire reg_req_t         req,
   input  wire conv_t            local_conv,
   input  wire conv_t            remote_conv,
   input  wire logic [7:0]       remote_high_limit_hi,
   input  wire logic [7:0]       remote_low_limit_hi,
   output logic [7:0]            rd_data_ff,
   output logic                  rd_valid_ff,
   output logic                  rd_hit_ff,
   output logic                  local_hi_hold_ff,
   output logic                  remote_above_high_ff,
   output logic                  remote_below_low_ff,
   output logic                  overtemp_shutdown_output_ff
);
   function automatic logic owns_ptr(input logic [7:0] p);
      owns_ptr = (p == PTR_REMOTE_HIGH_FRAC) || (p == PTR_REMOTE_LOW_FRAC)
         || (p == PTR_LOCAL_FRAC) || (p == PTR_REMOTE_OT)
         || (p == PTR_LOCAL_OT) || (p == PTR_OT_HYST);
   endfunction : owns_ptr

   logic [3:0] remote_high_limit_frac_bits_ff;
   logic [3:0] remote_low_limit_frac_bits_ff;
   logic [3:0] local_result_frac_bits_ff;
   logic [7:0] remote_overtemp_limit_bits_ff;
   logic [7:0] local_overtemp_limit_bits_ff;
   logic [7:0] overtemp_hysteresis_bits_ff;
   lock_st_t   lock_st_ff;
   lock_st_t   nxt_lock_st;

   // write decode
   wire wr_high_frac = req.wr && (req.ptr == PTR_REMOTE_HIGH_FRAC);
   wire wr_low_frac  = req.wr && (req.ptr == PTR_REMOTE_LOW_FRAC);
   wire wr_rmt_ot    = req.wr && (req.ptr == PTR_REMOTE_OT);
   wire wr_loc_ot    = req.wr && (req.ptr == PTR_LOCAL_OT);
   wire wr_hyst      = req.wr && (req.ptr == PTR_OT_HYST);

   // read decode for the lock
   wire rd_loc_hi    = req.rd && (req.ptr == PTR_LOCAL_RESULT_HI);
   wire rd_loc_frac  = req.rd && (req.ptr == PTR_LOCAL_FRAC);
   wire rd_other     = req.rd && !rd_loc_hi && !rd_loc_frac;

   // a completed pair returns to unlocked; a lone read holds its partner
   assign nxt_lock_st =
      rd_other                              ? LOCK_NONE :
      (rd_loc_hi && lock_st_ff == LOCK_HI)  ? LOCK_NONE :
      rd_loc_hi                             ? LOCK_FRAC :
      (rd_loc_frac && lock_st_ff == LOCK_FRAC) ? LOCK_NONE :
      rd_loc_frac                           ? LOCK_HI   :
      lock_st_ff;

   // the converter writes only while the fraction is not held
   wire frac_upd = local_conv.done && (lock_st_ff != LOCK_FRAC);

   // read selection; reserved low nibbles and foreign pointers read zero
   wire [7:0] rd_sel =
      (req.ptr == PTR_REMOTE_HIGH_FRAC) ? {remote_high_limit_frac_bits_ff, 4'h0} :
      (req.ptr == PTR_REMOTE_LOW_FRAC)  ? {remote_low_limit_frac_bits_ff, 4'h0} :
      (req.ptr == PTR_LOCAL_FRAC)       ? {local_result_frac_bits_ff, 4'h0} :
      (req.ptr == PTR_REMOTE_OT)        ? remote_overtemp_limit_bits_ff :
      (req.ptr == PTR_LOCAL_OT)         ? local_overtemp_limit_bits_ff :
      (req.ptr == PTR_OT_HYST)          ? overtemp_hysteresis_bits_ff :
      RD_DATA_RST;

   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         remote_high_limit_frac_bits_ff <= FRAC_RST;
         remote_low_limit_frac_bits_ff  <= FRAC_RST;
         remote_overtemp_limit_bits_ff  <= REMOTE_OT_RST;
         local_overtemp_limit_bits_ff   <= LOCAL_OT_RST;
         overtemp_hysteresis_bits_ff    <= OT_HYST_RST;
      end
      else
      begin
         if (wr_high_frac)
            remote_high_limit_frac_bits_ff <= req.wdata[7:4];
         if (wr_low_frac)
            remote_low_limit_frac_bits_ff <= req.wdata[7:4];
         if (wr_rmt_ot)
            remote_overtemp_limit_bits_ff <= req.wdata;
         if (wr_loc_ot)
            local_overtemp_limit_bits_ff <= req.wdata;
         if (wr_hyst)
            overtemp_hysteresis_bits_ff <= req.wdata;
      end
   end

   // no write path reaches the result fraction
   always_ff @(posedge sys_clk)
   begin
      if (srst)
         local_result_frac_bits_ff <= FRAC_RST;
      else if (frac_upd)
         local_result_frac_bits_ff <= local_conv.result[3:0];
   end

   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         lock_st_ff       <= LOCK_NONE;
         local_hi_hold_ff <= 1'b0;
      end
      else
      begin
         lock_st_ff       <= nxt_lock_st;
         local_hi_hold_ff <= (nxt_lock_st == LOCK_HI);
      end
   end

   // read data show the value before any same-cycle update
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         rd_data_ff  <= RD_DATA_RST;
         rd_valid_ff <= 1'b0;
         rd_hit_ff   <= 1'b0;
      end
      else
      begin
         rd_valid_ff <= req.rd;
         rd_hit_ff   <= req.rd && owns_ptr(req.ptr);
         if (req.rd)
            rd_data_ff <= rd_sel;
      end
   end

   remote_window_cmp u_window (
      .sys_clk   (sys_clk),
      .srst      (srst),
      .conv      (remote_conv),
      .high_hi   (remote_high_limit_hi),
      .high_frac (remote_high_limit_frac_bits_ff),
      .low_hi    (remote_low_limit_hi),
      .low_frac  (remote_low_limit_frac_bits_ff),
      .above_ff  (remote_above_high_ff),
      .below_ff  (remote_below_low_ff)
   );

   conv_t      chan_conv [CHAN_N];
   logic [7:0] chan_lim  [CHAN_N];
   logic [CHAN_N-1:0] chan_over;

   assign chan_conv[CHAN_REMOTE] = remote_conv;
   assign chan_conv[CHAN_LOCAL]  = local_conv;
   assign chan_lim[CHAN_REMOTE]  = remote_overtemp_limit_bits_ff;
   assign chan_lim[CHAN_LOCAL]   = local_overtemp_limit_bits_ff;

   // one hysteresis value serves both channels
   for (genvar ch = 0; ch < CHAN_N; ch++)
   begin : g_ot
      overtemp_hyst u_ot (
         .sys_clk (sys_clk),
         .srst    (srst),
         .conv    (chan_conv[ch]),
         .limit   (chan_lim[ch]),
         .hyst    (overtemp_hysteresis_bits_ff),
         .over_ff (chan_over[ch])
      );
   end

   // one extra cycle of latency buys a flop-driven pin
   always_ff @(posedge sys_clk)
   begin
      if (srst)
         overtemp_shutdown_output_ff <= 1'b0;
      else
         overtemp_shutdown_output_ff <= |chan_over;
   end

   // the flops show reset one edge after srst is sampled; skip that edge as well
   logic rst_seen_ff;

   always_ff @(posedge sys_clk)
   begin
      rst_seen_ff <= srst;
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst || rst_seen_ff);

   frac_update_a: assert property (
      local_conv.done && (lock_st_ff != LOCK_FRAC)
      |=> local_result_frac_bits_ff == $past(local_conv.result[3:0]))
      else $error("fraction not refreshed by conversion");
   frac_held_a: assert property (
      rd_loc_hi && (lock_st_ff == LOCK_NONE) ##1 (lock_st_ff == LOCK_FRAC)
      |=> $stable(local_result_frac_bits_ff))
      else $error("fraction changed while held");
   hi_held_a: assert property (
      rd_loc_frac && (lock_st_ff == LOCK_NONE)
      |=> local_hi_hold_ff ##0 (lock_st_ff == LOCK_HI))
      else $error("high byte not held after fraction read");
   lock_release_a: assert property (
      rd_other |=> !local_hi_hold_ff && (lock_st_ff == LOCK_NONE))
      else $error("lock survived other read");
   frac_ro_a: assert property (
      req.wr && (req.ptr == PTR_LOCAL_FRAC) && !local_conv.done
      |=> $stable(local_result_frac_bits_ff))
      else $error("write changed result fraction");
   // host traffic leaves one idle edge between commands
   high_frac_rw_a: assert property (
      wr_high_frac ##1 !wr_high_frac ##1 (req.rd && req.ptr == PTR_REMOTE_HIGH_FRAC && !req.wr)
      |=> rd_data_ff == {$past(req.wdata, 3) & 8'hf0})
      else $error("high limit fraction readback wrong");
   low_frac_rd_a: assert property (
      req.rd && (req.ptr == PTR_REMOTE_LOW_FRAC)
      |=> rd_data_ff == {$past(remote_low_limit_frac_bits_ff), 4'h0} && rd_hit_ff)
      else $error("low limit fraction read wrong");
   rmt_ot_wr_a: assert property (
      wr_rmt_ot |=> remote_overtemp_limit_bits_ff == $past(req.wdata))
      else $error("remote overtemp limit not written");
   ot_reset_a: assert property (
      $fell(srst) |-> local_overtemp_limit_bits_ff == LOCAL_OT_RST
         && remote_overtemp_limit_bits_ff == REMOTE_OT_RST
         && overtemp_hysteresis_bits_ff == OT_HYST_RST)
      else $error("limit reset values wrong");
   hyst_rd_a: assert property (
      req.rd && (req.ptr == PTR_OT_HYST)
      |=> rd_data_ff == $past(overtemp_hysteresis_bits_ff) && rd_valid_ff)
      else $error("hysteresis read wrong");
   shutdown_a: assert property (
      ##1 (overtemp_shutdown_output_ff == $past(|chan_over)))
      else $error("shutdown output not following channels");

   // pointer writes land on the strobe edge, reads show the value before it
   high_frac_wr_a: assert property (
      wr_high_frac |=> remote_high_limit_frac_bits_ff == $past(req.wdata[7:4]))
      else $error("high limit fraction not written");
   high_frac_rd_a: assert property (
      req.rd && (req.ptr == PTR_REMOTE_HIGH_FRAC)
      |=> rd_data_ff == {$past(remote_high_limit_frac_bits_ff), 4'h0} && rd_hit_ff)
      else $error("high limit fraction read wrong");
   low_frac_wr_a: assert property (
      wr_low_frac |=> remote_low_limit_frac_bits_ff == $past(req.wdata[7:4]))
      else $error("low limit fraction not written");
   loc_ot_wr_a: assert property (
      wr_loc_ot |=> local_overtemp_limit_bits_ff == $past(req.wdata))
      else $error("local overtemp limit not written");
   hyst_wr_a: assert property (
      wr_hyst |=> overtemp_hysteresis_bits_ff == $past(req.wdata))
      else $error("hysteresis not written");
   rmt_ot_rd_a: assert property (
      req.rd && (req.ptr == PTR_REMOTE_OT)
      |=> rd_data_ff == $past(remote_overtemp_limit_bits_ff) && rd_hit_ff)
      else $error("remote overtemp limit read wrong");
   loc_ot_rd_a: assert property (
      req.rd && (req.ptr == PTR_LOCAL_OT)
      |=> rd_data_ff == $past(local_overtemp_limit_bits_ff) && rd_hit_ff)
      else $error("local overtemp limit read wrong");
   stray_wr_a: assert property (
      req.wr && (!owns_ptr(req.ptr) || (req.ptr == PTR_LOCAL_FRAC))
      |=> $stable(remote_overtemp_limit_bits_ff) && $stable(local_overtemp_limit_bits_ff)
         && $stable(overtemp_hysteresis_bits_ff) && $stable(remote_high_limit_frac_bits_ff))
      else $error("write to a foreign pointer changed a register");

   // pair lock: only reads move it
   frac_rd_a: assert property (
      req.rd && (req.ptr == PTR_LOCAL_FRAC)
      |=> rd_data_ff == {$past(local_result_frac_bits_ff), 4'h0} && rd_hit_ff)
      else $error("result fraction read wrong");
   frac_blocked_a: assert property (
      local_conv.done && (lock_st_ff == LOCK_FRAC) |=> $stable(local_result_frac_bits_ff))
      else $error("conversion reached held fraction");
   hi_first_a: assert property (
      rd_loc_hi && (lock_st_ff != LOCK_HI) |=> lock_st_ff == LOCK_FRAC)
      else $error("high byte read did not hold fraction");
   frac_pair_a: assert property (
      rd_loc_frac && (lock_st_ff == LOCK_FRAC) |=> lock_st_ff == LOCK_NONE)
      else $error("fraction read did not end pair");
   hi_pair_a: assert property (
      rd_loc_hi && (lock_st_ff == LOCK_HI) |=> !local_hi_hold_ff && (lock_st_ff == LOCK_NONE))
      else $error("high byte read did not end pair");
   hold_state_a: assert property (
      local_hi_hold_ff == (lock_st_ff == LOCK_HI))
      else $error("high byte hold disagrees with lock");
   lock_idle_a: assert property (
      !req.rd |=> $stable(lock_st_ff))
      else $error("lock moved without a read");
   foreign_rd_a: assert property (
      req.rd && !owns_ptr(req.ptr) && (req.ptr != PTR_LOCAL_RESULT_HI)
      |=> (rd_data_ff == RD_DATA_RST) && !rd_hit_ff && (lock_st_ff == LOCK_NONE))
      else $error("foreign read not empty or lock kept");

   // read answer: one pulse per read, data held between reads
   rd_pulse_a: assert property (
      ##1 rd_valid_ff == $past(req.rd))
      else $error("read valid not one edge after strobe");
   rd_hold_a: assert property (
      !req.rd |=> $stable(rd_data_ff) && !rd_hit_ff)
      else $error("read data moved without a read");
   frac_reset_a: assert property (
      $fell(srst) |-> remote_high_limit_frac_bits_ff == FRAC_RST
         && remote_low_limit_frac_bits_ff == FRAC_RST
         && local_result_frac_bits_ff == FRAC_RST && lock_st_ff == LOCK_NONE)
      else $error("fraction reset values wrong");
endmodule : temp_limit_result_regs

// >>> design/temp_limit_pkg.sv
// constants, carriers and states shared by the temperature limit/result register bank
// assumes a serial front end that decodes pointer reads/writes into one-cycle strobes
// Summary of operation
// - remote high limit fraction stored in bits 7:4, sixteenth degree steps, writable
// - remote low limit fraction stored in bits 7:4, sixteenth degree steps, writable
// - local fraction byte read-only, refreshed each local conversion unless held by a high byte read
// - reading local high byte first freezes the fraction byte until it is read
// - reading fraction byte first freezes the high byte until it is read
// - reading any other register drops the pair lock, updates resume
// - remote overtemp limit, 8 bits whole degrees, resets to 6Ch
// - local overtemp limit, 8 bits whole degrees, resets to 55h
// - overtemp hysteresis register read and written at 21h, resets to 0Ah
// - writes to the local fraction pointer leave it unchanged
// - overtemp releases only once temperature falls more than hysteresis below the limit
package temp_limit_pkg;
   localparam int BYTE_W = 8;
   localparam int FRAC_W = 4;
   localparam int TEMP_W = 12;
   localparam int CHAN_N = 2;

   localparam logic [7:0] PTR_LOCAL_RESULT_HI  = 8'h00;
   localparam logic [7:0] PTR_REMOTE_HIGH_FRAC = 8'h13;
   localparam logic [7:0] PTR_REMOTE_LOW_FRAC  = 8'h14;
   localparam logic [7:0] PTR_LOCAL_FRAC       = 8'h15;
   localparam logic [7:0] PTR_REMOTE_OT        = 8'h19;
   localparam logic [7:0] PTR_LOCAL_OT         = 8'h20;
   localparam logic [7:0] PTR_OT_HYST          = 8'h21;

   localparam logic [3:0] FRAC_RST      = 4'h0;
   localparam logic [7:0] REMOTE_OT_RST = 8'h6c;
   localparam logic [7:0] LOCAL_OT_RST  = 8'h55;
   localparam logic [7:0] OT_HYST_RST   = 8'h0a;
   localparam logic [7:0] RD_DATA_RST   = 8'h00;

   localparam int CHAN_REMOTE = 0;
   localparam int CHAN_LOCAL  = 1;

   typedef struct packed {
      logic       rd;
      logic       wr;
      logic [7:0] ptr;
      logic [7:0] wdata;
   } reg_req_t;

   typedef struct packed {
      logic        done;
      logic [11:0] result;
   } conv_t;

   typedef enum logic [1:0] {
      LOCK_NONE,
      LOCK_FRAC,
      LOCK_HI
   } lock_st_t;
endpackage : temp_limit_pkg

// >>> design/remote_window_cmp.sv
// twelve-bit window comparison of the remote result against the high and low limits
// assumes conv.done is a one-cycle pulse with the result valid in the same cycle
module remote_window_cmp
   import temp_limit_pkg::*;
(
   input  wire logic             sys_clk,
   input  wire logic             srst,
   input  wire conv_t            conv,
   input  wire logic [7:0]       high_hi,
   input  wire logic [3:0]       high_frac,
   input  wire logic [7:0]       low_hi,
   input  wire logic [3:0]       low_frac,
   output logic                  above_ff,
   output logic                  below_ff
);
   wire [11:0] high_lim  = {high_hi, high_frac};
   wire [11:0] low_lim   = {low_hi, low_frac};
   wire        nxt_above = conv.result > high_lim;
   wire        nxt_below = conv.result < low_lim;

   // verdict held between conversions
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         above_ff <= 1'b0;
         below_ff <= 1'b0;
      end
      else if (conv.done)
      begin
         above_ff <= nxt_above;
         below_ff <= nxt_below;
      end
   end

   // the flops show reset one edge after srst is sampled; skip that edge as well
   logic rst_seen_ff;

   always_ff @(posedge sys_clk)
   begin
      rst_seen_ff <= srst;
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst || rst_seen_ff);

   cmp_high_low_a: assert property (
      conv.done |=> (above_ff == ($past(conv.result) > {$past(high_hi), $past(high_frac)}))
         && (below_ff == ($past(conv.result) < {$past(low_hi), $past(low_frac)})))
      else $error("remote window verdict wrong");
   cmp_hold_a: assert property (
      !conv.done |=> $stable(above_ff) && $stable(below_ff))
      else $error("remote window verdict moved without conversion");
endmodule : remote_window_cmp

// >>> design/overtemp_hyst.sv
// one overtemperature channel: set at the limit, cleared once more than hysteresis below it
// assumes whole-degree comparison on the result's upper byte
module overtemp_hyst
   import temp_limit_pkg::*;
(
   input  wire logic             sys_clk,
   input  wire logic             srst,
   input  wire conv_t            conv,
   input  wire logic [7:0]       limit,
   input  wire logic [7:0]       hyst,
   output logic                  over_ff
);
   wire [7:0] temp     = conv.result[11:4];
   // nine bits so a large hysteresis cannot wrap
   wire [8:0] temp_up  = {1'b0, temp} + {1'b0, hyst};
   wire       hot      = temp >= limit;
   wire       cool     = temp_up < {1'b0, limit};
   wire       nxt_over = hot | (over_ff & ~cool);

   always_ff @(posedge sys_clk)
   begin
      if (srst)
         over_ff <= 1'b0;
      else if (conv.done)
         over_ff <= nxt_over;
   end

   // the flops show reset one edge after srst is sampled; skip that edge as well
   logic rst_seen_ff;

   always_ff @(posedge sys_clk)
   begin
      rst_seen_ff <= srst;
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst || rst_seen_ff);

   hyst_release_a: assert property (
      over_ff && conv.done && ({1'b0, conv.result[11:4]} + {1'b0, hyst} >= {1'b0, limit})
      |=> over_ff)
      else $error("overtemp released inside hysteresis band");
   hyst_set_a: assert property (
      conv.done && (conv.result[11:4] >= limit) |=> over_ff)
      else $error("overtemp not set at limit");
endmodule : overtemp_hyst

// >>> dv/reg_host.sv
// host side of the register port: one pointer transfer at a time
// assumes the bench clock and a device that answers a read one cycle after its strobe
module reg_host
   import temp_limit_pkg::*;
(
   input  wire logic       sys_clk,
   input  wire logic       rd_valid_ff,
   input  wire logic       rd_hit_ff,
   input  wire logic [7:0] rd_data_ff,
   output reg_req_t        req
);
   timeunit 1ns;
   timeprecision 1ps;

   initial req = '0;

   // strobe held for exactly one sampling edge, answer taken 1 ns after that same edge
   // callers read the high byte and its fraction in either order, at times with other commands between
   task automatic xfer(input logic rd, input logic wr, input logic [7:0] ptr,
                       input logic [7:0] wd, output logic [7:0] data, output logic hit,
                       output logic vld);
      @(posedge sys_clk);
      req <= '{rd: rd, wr: wr, ptr: ptr, wdata: wd};
      @(posedge sys_clk);
      req <= '0;
      #1;
      data = rd_data_ff;
      hit = rd_hit_ff;
      vld = rd_valid_ff;
   endtask : xfer
endmodule : reg_host

// >>> dv/testbench.sv
// self-checking bench for the limit/result register bank
// assumes reg_host carries all pointer traffic; converter pulses come from here
module testbench
   import temp_limit_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   typedef struct packed {
      logic       wr;
      logic [7:0] ptr;
      logic [7:0] wd;
      logic [7:0] exp;
      logic       hit;
   } row_t;

   logic       sys_clk;
   logic       srst;
   reg_req_t   req;
   conv_t      local_conv;
   conv_t      remote_conv;
   logic [7:0] remote_high_limit_hi;
   logic [7:0] remote_low_limit_hi;
   logic [7:0] rd_data_ff;
   logic       rd_valid_ff, rd_hit_ff, local_hi_hold_ff;
   logic       remote_above_high_ff, remote_below_low_ff, overtemp_shutdown_output_ff;
   int         n_errors;
   int         checked;
   logic [7:0] d;
   logic       h;
   logic       v;
   row_t       rows [13];

   temp_limit_result_regs u_dut (
      .sys_clk(sys_clk), .srst(srst), .req(req), .local_conv(local_conv),
      .remote_conv(remote_conv), .remote_high_limit_hi(remote_high_limit_hi),
      .remote_low_limit_hi(remote_low_limit_hi), .rd_data_ff(rd_data_ff),
      .rd_valid_ff(rd_valid_ff), .rd_hit_ff(rd_hit_ff), .local_hi_hold_ff(local_hi_hold_ff),
      .remote_above_high_ff(remote_above_high_ff), .remote_below_low_ff(remote_below_low_ff),
      .overtemp_shutdown_output_ff(overtemp_shutdown_output_ff)
   );

   reg_host u_host (
      .sys_clk(sys_clk), .rd_valid_ff(rd_valid_ff), .rd_hit_ff(rd_hit_ff),
      .rd_data_ff(rd_data_ff), .req(req)
   );

   initial
   begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end

   task automatic tally_and_finish();
      $display("checks %0d, mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : tally_and_finish

   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      checked++;
      if (got !== exp)
      begin
         n_errors++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk

   task automatic rd(input logic [7:0] ptr, input logic [7:0] exp);
      u_host.xfer(1'b1, 1'b0, ptr, 8'h00, d, h, v);
      chk(d, exp, "read data");
   endtask : rd

   task automatic wr(input logic [7:0] ptr, input logic [7:0] wd);
      u_host.xfer(1'b0, 1'b1, ptr, wd, d, h, v);
   endtask : wr

   // sel 0 shutdown pin, 1 above-high flag, 2 below-low flag; pin settles two edges after done
   task automatic cv(input logic rem, input logic [11:0] r, input int sel, input logic exp);
      @(posedge sys_clk);
      if (rem)
         remote_conv <= '{done: 1'b1, result: r};
      else
         local_conv <= '{done: 1'b1, result: r};
      @(posedge sys_clk);
      remote_conv.done <= 1'b0;
      local_conv.done <= 1'b0;
      @(posedge sys_clk);
      #1;
      case (sel)
         0: chk({7'h0, overtemp_shutdown_output_ff}, {7'h0, exp}, "shutdown pin");
         1: chk({7'h0, remote_above_high_ff}, {7'h0, exp}, "above high");
         default: chk({7'h0, remote_below_low_ff}, {7'h0, exp}, "below low");
      endcase
   endtask : cv

   // watchdog: a hang ends in the same report
   initial
   begin
      repeat (5000) @(posedge sys_clk);
      n_errors++;
      $display("MISMATCH t=%0t run did not finish", $time);
      tally_and_finish();
   end

   initial
   begin
      srst = 1'b1;
      local_conv = '0;
      remote_conv = '0;
      remote_high_limit_hi = 8'h40;
      remote_low_limit_hi = 8'h10;
      n_errors = 0;
      checked = 0;
      rows[0] = '{1'b0, PTR_REMOTE_HIGH_FRAC, 8'h00, 8'h00, 1'b1};
      rows[1] = '{1'b0, PTR_REMOTE_LOW_FRAC, 8'h00, 8'h00, 1'b1};
      rows[2] = '{1'b0, PTR_LOCAL_FRAC, 8'h00, 8'h00, 1'b1};
      rows[3] = '{1'b0, PTR_REMOTE_OT, 8'h00, 8'h6c, 1'b1};
      rows[4] = '{1'b0, PTR_LOCAL_OT, 8'h00, 8'h55, 1'b1};
      rows[5] = '{1'b0, PTR_OT_HYST, 8'h00, 8'h0a, 1'b1};
      rows[6] = '{1'b1, PTR_REMOTE_HIGH_FRAC, 8'hff, 8'hf0, 1'b1};
      rows[7] = '{1'b1, PTR_REMOTE_LOW_FRAC, 8'ha5, 8'ha0, 1'b1};
      rows[8] = '{1'b1, PTR_REMOTE_OT, 8'haa, 8'haa, 1'b1};
      rows[9] = '{1'b1, PTR_LOCAL_OT, 8'h3c, 8'h3c, 1'b1};
      rows[10] = '{1'b1, PTR_OT_HYST, 8'h05, 8'h05, 1'b1};
      rows[11] = '{1'b1, PTR_LOCAL_FRAC, 8'hff, 8'h00, 1'b1};
      rows[12] = '{1'b1, 8'h30, 8'h77, 8'h00, 1'b0};
      repeat (20) @(posedge sys_clk);
      srst <= 1'b0;
      foreach (rows[i])
      begin
         if (rows[i].wr)
            wr(rows[i].ptr, rows[i].wd);
         rd(rows[i].ptr, rows[i].exp);
         chk({7'h0, h}, {7'h0, rows[i].hit}, "hit");
         chk({7'h0, v}, 8'h01, "valid");
      end
      cv(1'b0, 12'h5a3, 0, 1'b1);
      rd(PTR_LOCAL_FRAC, 8'h30);
      wr(PTR_LOCAL_RESULT_HI, 8'h00);
      rd(PTR_LOCAL_RESULT_HI, 8'h00);
      chk({7'h0, local_hi_hold_ff}, 8'h00, "pair closed by high");
      rd(PTR_LOCAL_RESULT_HI, 8'h00);
      cv(1'b0, 12'h5a7, 0, 1'b1);
      rd(PTR_LOCAL_FRAC, 8'h30);
      cv(1'b0, 12'h5a9, 0, 1'b1);
      rd(PTR_LOCAL_FRAC, 8'h90);
      chk({7'h0, local_hi_hold_ff}, 8'h01, "hold after fraction");
      rd(PTR_LOCAL_RESULT_HI, 8'h00);
      chk({7'h0, local_hi_hold_ff}, 8'h00, "hold after high");
      rd(PTR_LOCAL_FRAC, 8'h90);
      rd(PTR_REMOTE_OT, 8'haa);
      chk({7'h0, local_hi_hold_ff}, 8'h00, "hold after other");
      rd(PTR_LOCAL_RESULT_HI, 8'h00);
      rd(PTR_OT_HYST, 8'h05);
      cv(1'b0, 12'h5ac, 0, 1'b1);
      rd(PTR_LOCAL_FRAC, 8'hc0);
      cv(1'b0, 12'h360, 0, 1'b0);
      cv(1'b0, 12'h3bf, 0, 1'b0);
      cv(1'b0, 12'h3c0, 0, 1'b1);
      cv(1'b0, 12'h370, 0, 1'b1);
      cv(1'b0, 12'h36f, 0, 1'b0);
      cv(1'b1, 12'h40f, 1, 1'b0);
      cv(1'b1, 12'h410, 1, 1'b1);
      cv(1'b1, 12'h109, 2, 1'b1);
      cv(1'b1, 12'h10a, 2, 1'b0);
      wr(PTR_REMOTE_OT, 8'h41);
      cv(1'b1, 12'h410, 0, 1'b1);
      wr(PTR_OT_HYST, 8'h33);
      @(posedge sys_clk);
      srst <= 1'b1;
      @(posedge sys_clk);
      srst <= 1'b0;
      rd(PTR_OT_HYST, 8'h0a);
      rd(PTR_REMOTE_OT, 8'h6c);
      chk({7'h0, overtemp_shutdown_output_ff}, 8'h00, "pin after reset");
      tally_and_finish();
   end
endmodule : testbench
